// *** design/clkgen_pkg.sv ***
// Constants, types and helper functions of the audio clock control block.
// Assumes a 200 MHz system clock and a slow link oversampling clock.
// Function
// - Mode high uses strap pins; mode low uses the I2C control byte.
// - An unconnected mode input behaves as low, selecting I2C control.
// - Shared pin is I2C clock in software mode, frequency strap otherwise.
// - Shared pin is I2C data in software mode, scale strap otherwise.
// - Rate strap decoded only in hardwired mode, ignored in software mode.
// - Active-low reset returns the control byte to its default.
// - Audio clocks run at 256, 384 or 768 fs; low when disabled.
// - Reference output carries the reference clock when enabled, else low.
// - Address pin A is I2C address in software, reference enable otherwise.
// - Address pin B is I2C address in software, audio enables otherwise.
// - Rates 12, 32, 44.1, 48 kHz standard; 64, 88.2, 96 kHz double.
// - Audio frequency equals scaling factor times sampling frequency.
// - Outputs settle about 10 ms after an I2C frequency change.
// - Outputs settle about 15 ms after power-on or reset.
// - Byte bits: 7 ref, 6 B, 5 A, 4 rate, 3:2 scale, 1:0 freq.
// - Reset gives 256 x 32 kHz in software mode, strap values otherwise.
// - At power-up both address pins are sampled and the address latched.
// - Scale strap: low 256, high 384, open 768.

package clkgen_pkg;

   // ***********************************************************
   // Timing
   // ***********************************************************
   localparam int MCLK_MHZ = 200;
   localparam int SETTLE_MS = 10;
   localparam int POWERON_MS = 15;
   localparam int SETTLE_CYCLES = SETTLE_MS * MCLK_MHZ * 1000;
   localparam int POWERON_CYCLES = POWERON_MS * MCLK_MHZ * 1000;
   localparam int PHASE_W = 32;

   // ***********************************************************
   // Control byte layout
   // ***********************************************************
   localparam int BIT_REF_EN = 7;
   localparam int BIT_B_EN = 6;
   localparam int BIT_A_EN = 5;
   localparam int BIT_RATE = 4;
   localparam int SCALE_LSB = 2;
   localparam int FREQ_LSB = 0;
   localparam logic [7:0] CTRL_RESET = 8'he0;

   // ***********************************************************
   // Selections
   // ***********************************************************
   typedef enum logic [1:0]
   {
      LVL_LOW = 2'b00,
      LVL_HIGH = 2'b01,
      LVL_OPEN = 2'b10
   } level_e;

   localparam logic [2:0] FS_12K = 3'h0;
   localparam logic [2:0] FS_32K = 3'h1;
   localparam logic [2:0] FS_44K1 = 3'h2;
   localparam logic [2:0] FS_48K = 3'h3;
   localparam logic [2:0] FS_DOUBLE_STEP = 3'h3;
   localparam int FS_COUNT = 7;
   localparam logic [1:0] SCALE_256 = 2'h0;
   localparam logic [1:0] SCALE_384 = 2'h1;
   localparam logic [1:0] SCALE_768 = 2'h2;
   localparam int SCALE_COUNT = 3;
   localparam int FS_HZ [0:FS_COUNT-1] =
      '{12000, 32000, 44100, 48000, 64000, 88200, 96000};
   localparam int SCALE_MULT [0:SCALE_COUNT-1] = '{256, 384, 768};

   // ***********************************************************
   // Functions
   // ***********************************************************
   function automatic logic [PHASE_W-1:0] phase_inc(input longint fs,
                                                    input longint mult);
      longint den;
      longint num;
      den = longint'(MCLK_MHZ) * 1000000;
      num = ((fs * mult) << PHASE_W) + den / 2;
      return PHASE_W'(num / den);
   endfunction : phase_inc

   function automatic level_e resolve(input logic lvl, input logic open);
      if (open)
         return LVL_OPEN;
      return lvl ? LVL_HIGH : LVL_LOW;
   endfunction : resolve

   function automatic logic [6:0] addr_lookup(input level_e a,
                                              input level_e b);
      logic [6:0] r;
      r = 7'h60;
      case ({a, b})
         {LVL_OPEN, LVL_OPEN}: r = 7'h60;
         {LVL_LOW, LVL_OPEN}: r = 7'h63;
         {LVL_HIGH, LVL_OPEN}: r = 7'h62;
         {LVL_OPEN, LVL_LOW}: r = 7'h64;
         {LVL_LOW, LVL_LOW}: r = 7'h68;
         {LVL_HIGH, LVL_LOW}: r = 7'h70;
         {LVL_OPEN, LVL_HIGH}: r = 7'h71;
         {LVL_LOW, LVL_HIGH}: r = 7'h72;
         {LVL_HIGH, LVL_HIGH}: r = 7'h74;
         default: r = 7'h60;
      endcase
      return r;
   endfunction : addr_lookup

endpackage : clkgen_pkg

// *** design/ctrl_link_if.sv ***
// Carrier between the system-clock core and the link-clock I2C slave.
// Words are held stable after the toggle or level that announces them.
`timescale 1ns/1ps

interface ctrl_link_if;
   logic wr_toggle;
   logic [7:0] wr_data;
   logic [6:0] slave_addr;
   logic addr_valid;
   logic sw_mode;

   modport link (output wr_toggle, output wr_data,
                 input slave_addr, input addr_valid, input sw_mode);
   modport core (input wr_toggle, input wr_data,
                 output slave_addr, output addr_valid, output sw_mode);
endinterface : ctrl_link_if

// *** design/i2c_ctrl_slave.sv ***
// I2C write-only slave taking one control byte, on the link clock.
// Assumes the link clock oversamples the bus lines at least tenfold.
`timescale 1ns/1ps

module i2c_ctrl_slave
(
   input wire logic link_clk,
   input wire logic rst_n,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_oe,
   ctrl_link_if.link bus
);

   // ***********************************************************
   // Synchronisers
   // ***********************************************************
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b000,
      ST_ADDR = 3'b001,
      ST_ACK_A = 3'b010,
      ST_DATA = 3'b011,
      ST_ACK_D = 3'b100,
      ST_SKIP = 3'b101
   } state_e;

   logic [3:0] s1;
   logic [3:0] s2;
   logic scl_q;
   logic sda_q;
   state_e state;
   logic [3:0] cnt;
   logic [7:0] shift;
   logic [6:0] my_addr;

   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         // Bus bits reset to idle high, so no false edge follows reset
         s1 <= 4'h3;
         s2 <= 4'h3;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end
      else
      begin
         s1 <= {bus.sw_mode, bus.addr_valid, scl_in, sda_in};
         s2 <= s1;
         scl_q <= s2[1];
         sda_q <= s2[0];
      end
   end

   wire sw_mode_s = s2[3];
   wire addr_ok = s2[2];
   wire scl = s2[1];
   wire sda = s2[0];
   wire scl_rise = scl && !scl_q;
   wire scl_fall = !scl && scl_q;
   // Start only counts while the link is the active path; stop counts in either mode
   wire start_cond = sw_mode_s && scl && scl_q && sda_q && !sda;
   wire stop_cond = scl && scl_q && !sda_q && sda;
   wire byte_done = (cnt == 4'h8);
   wire addr_hit = addr_ok && (shift[7:1] == my_addr) && !shift[0];

   // ***********************************************************
   // Address capture
   // ***********************************************************
   // Address is static once valid, so one capture is a safe crossing
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
         my_addr <= 7'h00;
      else if (addr_ok && state == ST_IDLE)
         my_addr <= bus.slave_addr;
   end

   // ***********************************************************
   // Bus state machine
   // ***********************************************************
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cnt <= 4'h0;
         shift <= 8'h00;
         sda_oe <= 1'b0;
         bus.wr_toggle <= 1'b0;
         bus.wr_data <= 8'h00;
      end
      else if (start_cond)
      begin
         state <= ST_ADDR;
         cnt <= 4'h0;
         sda_oe <= 1'b0;
      end
      else if (stop_cond || !sw_mode_s)
      begin
         state <= ST_IDLE;
         sda_oe <= 1'b0;
      end
      else if (scl_rise && (state == ST_ADDR || state == ST_DATA))
      begin
         shift <= {shift[6:0], sda};
         cnt <= cnt + 4'h1;
      end
      else if (scl_fall)
      begin
         case (state)
            ST_ADDR:
               if (byte_done)
               begin
                  state <= addr_hit ? ST_ACK_A : ST_SKIP;
                  sda_oe <= addr_hit;
               end
            ST_ACK_A, ST_ACK_D:
            begin
               state <= ST_DATA;
               cnt <= 4'h0;
               sda_oe <= 1'b0;
            end
            ST_DATA:
               if (byte_done)
               begin
                  state <= ST_ACK_D;
                  sda_oe <= 1'b1;
                  bus.wr_data <= shift;
                  bus.wr_toggle <= !bus.wr_toggle;
               end
            default:
               state <= state;
         endcase
      end
   end

endmodule : i2c_ctrl_slave

// *** design/audio_clock_config_control.sv ***
// Top of the audio clock configuration and control block.
// Assumes MCLK at 200 MHz, a free link sampling clock and a reference.
`timescale 1ns/1ps

module audio_clock_config_control
#(
   parameter int SETTLE_CYCLES = clkgen_pkg::SETTLE_CYCLES,
   parameter int POWERON_CYCLES = clkgen_pkg::POWERON_CYCLES
)
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic LINK_CLK,
   input wire logic REF_CLK,
   input wire logic MODE,
   input wire logic MODE_OPEN,
   input wire logic CLK_OR_FREQ_SEL_PIN,
   input wire logic CLK_OR_FREQ_SEL_OPEN,
   input wire logic DATA_OR_SCALE_SEL_IN,
   input wire logic DATA_OR_SCALE_SEL_OPEN,
   output logic DATA_OR_SCALE_SEL_OUT,
   output logic DATA_OR_SCALE_SEL_OE,
   input wire logic RATE_SEL_PIN,
   input wire logic RATE_SEL_OPEN,
   input wire logic ADDR_SEL_A_PIN,
   input wire logic ADDR_SEL_A_OPEN,
   input wire logic ADDR_SEL_B_PIN,
   input wire logic ADDR_SEL_B_OPEN,
   output logic AUDIO_CLK_A,
   output logic AUDIO_CLK_B,
   output logic REF_CLK_BUFFER_OUT,
   output logic [7:0] CTRL_BYTE,
   output logic SETTLING
);

   // ***********************************************************
   // Pin synchronisers
   // ***********************************************************
   localparam int NPIN = 10;

   ctrl_link_if link ();

   logic [NPIN-1:0] pin_s1;
   logic [NPIN-1:0] pin_s2;

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         pin_s1 <= '0;
         pin_s2 <= '0;
      end
      else
      begin
         pin_s1 <= {MODE, MODE_OPEN,
                    CLK_OR_FREQ_SEL_PIN, CLK_OR_FREQ_SEL_OPEN,
                    DATA_OR_SCALE_SEL_IN, DATA_OR_SCALE_SEL_OPEN,
                    RATE_SEL_PIN, RATE_SEL_OPEN,
                    ADDR_SEL_A_PIN, ADDR_SEL_A_OPEN};
         pin_s2 <= pin_s1;
      end
   end

   logic [1:0] addr_b_s1;
   logic [1:0] addr_b_s2;

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         addr_b_s1 <= 2'h0;
         addr_b_s2 <= 2'h0;
      end
      else
      begin
         addr_b_s1 <= {ADDR_SEL_B_PIN, ADDR_SEL_B_OPEN};
         addr_b_s2 <= addr_b_s1;
      end
   end

   // ***********************************************************
   // Three-level decoding
   // ***********************************************************
   // Open mode reads as low, like an internal pull-down
   wire hw_mode = pin_s2[9] && !pin_s2[8];
   wire clkgen_pkg::level_e lv_freq =
      clkgen_pkg::resolve(pin_s2[7], pin_s2[6]);
   wire clkgen_pkg::level_e lv_scale =
      clkgen_pkg::resolve(pin_s2[5], pin_s2[4]);
   wire clkgen_pkg::level_e lv_rate =
      clkgen_pkg::resolve(pin_s2[3], pin_s2[2]);
   wire clkgen_pkg::level_e lv_addr_a =
      clkgen_pkg::resolve(pin_s2[1], pin_s2[0]);
   wire clkgen_pkg::level_e lv_addr_b =
      clkgen_pkg::resolve(addr_b_s2[1], addr_b_s2[0]);

   // ***********************************************************
   // Address latch at power-up
   // ***********************************************************
   logic [1:0] boot_cnt;
   logic addr_valid;
   logic [6:0] slave_addr;

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         boot_cnt <= 2'h0;
         addr_valid <= 1'b0;
         slave_addr <= 7'h00;
      end
      else if (!addr_valid)
      begin
         boot_cnt <= boot_cnt + 2'h1;
         if (boot_cnt == 2'h3)
         begin
            addr_valid <= 1'b1;
            slave_addr <= clkgen_pkg::addr_lookup(lv_addr_a,
                                                  lv_addr_b);
         end
      end
   end

   assign link.slave_addr = slave_addr;
   assign link.addr_valid = addr_valid;
   assign link.sw_mode = !hw_mode;

   // ***********************************************************
   // I2C link and control byte
   // ***********************************************************
   i2c_ctrl_slave u_slave
   (
      .link_clk(LINK_CLK),
      .rst_n(RSTN),
      .scl_in(CLK_OR_FREQ_SEL_PIN),
      .sda_in(DATA_OR_SCALE_SEL_IN),
      .sda_oe(DATA_OR_SCALE_SEL_OE),
      .bus(link.link)
   );

   // Open-drain data line only ever pulls low
   assign DATA_OR_SCALE_SEL_OUT = 1'b0;

   logic [2:0] tog_sync;
   logic [7:0] ctrl;

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         tog_sync <= 3'h0;
      else
         tog_sync <= {tog_sync[1:0], link.wr_toggle};
   end

   // Data word moved with the toggle and is stable long before the toggle is synchronised
   wire wr_event = tog_sync[2] ^ tog_sync[1];

   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         ctrl <= clkgen_pkg::CTRL_RESET;
      else if (wr_event)
         ctrl <= link.wr_data;
   end

   // ***********************************************************
   // Effective selection
   // ***********************************************************
   wire [1:0] sw_freq = ctrl[clkgen_pkg::FREQ_LSB +: 2];
   wire [1:0] sw_scale = ctrl[clkgen_pkg::SCALE_LSB +: 2];
   wire sw_double = ctrl[clkgen_pkg::BIT_RATE];
   wire [2:0] sw_base = (sw_freq == 2'h3) ? clkgen_pkg::FS_12K :
                        3'(sw_freq) + clkgen_pkg::FS_32K;
   wire [2:0] sw_fs = (sw_double && sw_base != clkgen_pkg::FS_12K) ?
                      sw_base + clkgen_pkg::FS_DOUBLE_STEP : sw_base;
   wire [1:0] sw_sc = sw_scale[1] ? clkgen_pkg::SCALE_768 : sw_scale;

   wire [2:0] hw_base =
      (lv_freq == clkgen_pkg::LVL_LOW) ? clkgen_pkg::FS_32K :
      (lv_freq == clkgen_pkg::LVL_HIGH) ? clkgen_pkg::FS_44K1 :
      clkgen_pkg::FS_48K;
   // Open rate strap forces 12 kHz over the frequency strap
   wire [2:0] hw_fs =
      (lv_rate == clkgen_pkg::LVL_OPEN) ? clkgen_pkg::FS_12K :
      (lv_rate == clkgen_pkg::LVL_HIGH) ?
      hw_base + clkgen_pkg::FS_DOUBLE_STEP : hw_base;
   wire [1:0] hw_sc =
      (lv_scale == clkgen_pkg::LVL_LOW) ? clkgen_pkg::SCALE_256 :
      (lv_scale == clkgen_pkg::LVL_HIGH) ? clkgen_pkg::SCALE_384 :
      clkgen_pkg::SCALE_768;

   // Open address-A strap is reserved; treated as disabled
   wire hw_ref_en = (lv_addr_a == clkgen_pkg::LVL_HIGH);
   wire hw_a_en = (lv_addr_b != clkgen_pkg::LVL_HIGH);
   wire hw_b_en = (lv_addr_b != clkgen_pkg::LVL_LOW);

   wire [2:0] fs_sel = hw_mode ? hw_fs : sw_fs;
   wire [1:0] sc_sel = hw_mode ? hw_sc : sw_sc;
   wire ref_en = hw_mode ? hw_ref_en : ctrl[clkgen_pkg::BIT_REF_EN];
   wire a_en = hw_mode ? hw_a_en : ctrl[clkgen_pkg::BIT_A_EN];
   wire b_en = hw_mode ? hw_b_en : ctrl[clkgen_pkg::BIT_B_EN];

   // ***********************************************************
   // Phase increment table
   // ***********************************************************
   localparam int NSEL = clkgen_pkg::FS_COUNT * clkgen_pkg::SCALE_COUNT;

   wire [clkgen_pkg::PHASE_W-1:0] inc_rom [0:NSEL-1];

   for (genvar i = 0; i < clkgen_pkg::FS_COUNT; i++)
   begin : g_fs
      for (genvar j = 0; j < clkgen_pkg::SCALE_COUNT; j++)
      begin : g_sc
         assign inc_rom[i*clkgen_pkg::SCALE_COUNT+j] =
            clkgen_pkg::phase_inc(clkgen_pkg::FS_HZ[i],
                                  clkgen_pkg::SCALE_MULT[j]);
      end
   end

   wire [4:0] sel_idx = 5'(fs_sel * 3'h3) + 5'(sc_sel);
   wire [clkgen_pkg::PHASE_W-1:0] inc = inc_rom[sel_idx];

   // ***********************************************************
   // Settling and synthesis
   // ***********************************************************
   logic [4:0] sel_q;
   logic [31:0] mute_cnt;
   logic [clkgen_pkg::PHASE_W-1:0] phase;
   logic ref_en_q;

   // Audio outputs are held low until a new setting has had time to settle
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         sel_q <= 5'h0;
         mute_cnt <= 32'(POWERON_CYCLES);
      end
      else
      begin
         sel_q <= sel_idx;
         if (sel_idx != sel_q && addr_valid)
            mute_cnt <= 32'(SETTLE_CYCLES);
         else if (mute_cnt != 32'h0)
            mute_cnt <= mute_cnt - 32'h1;
      end
   end

   wire run = (mute_cnt == 32'h0);

   // Numerically controlled square wave; edge jitter is one MCLK period
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         phase <= '0;
         AUDIO_CLK_A <= 1'b0;
         AUDIO_CLK_B <= 1'b0;
         ref_en_q <= 1'b0;
      end
      else
      begin
         phase <= phase + inc;
         AUDIO_CLK_A <= phase[clkgen_pkg::PHASE_W-1] && a_en && run;
         AUDIO_CLK_B <= phase[clkgen_pkg::PHASE_W-1] && b_en && run;
         ref_en_q <= ref_en;
      end
   end

   assign CTRL_BYTE = ctrl;
   assign SETTLING = !run;

   // ***********************************************************
   // Reference buffer gate
   // ***********************************************************
   logic ref_s1;
   logic ref_s2;
   logic ref_gate;

   always_ff @(posedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
      begin
         ref_s1 <= 1'b0;
         ref_s2 <= 1'b0;
      end
      else
      begin
         ref_s1 <= ref_en_q;
         ref_s2 <= ref_s1;
      end
   end

   // Falling-edge enable keeps the gated clock free of runt pulses
   always_ff @(negedge REF_CLK or negedge RSTN)
   begin
      if (!RSTN)
         ref_gate <= 1'b0;
      else
         ref_gate <= ref_s2;
   end

   assign REF_CLK_BUFFER_OUT = REF_CLK && ref_gate;

endmodule : audio_clock_config_control

// *** tb/i2c_master_model.sv ***
// Behavioural I2C bus master writing one control byte.
// Assumes the DUT samples the bus on the same link clock.
`timescale 1ns/1ps

module i2c_master_model
(
   input wire logic link_clk,
   input wire logic sda_oe,
   output logic scl,
   output logic sda
);
   logic drv;

   // Pull-up wins wherever nobody pulls low
   assign sda = drv && !sda_oe;

   initial
   begin
      scl = 1'b1;
      drv = 1'b1;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge link_clk);
      #1;
   endtask : tick

   // Data moves well inside SCL low to keep hold time
   task automatic put(input logic b, output logic seen);
      tick(3);
      drv = b;
      tick(7);
      scl = 1'b1;
      tick(10);
      seen = sda;
      scl = 1'b0;
   endtask : put

   task automatic send(input logic [7:0] b, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         put(b[i], s);
      end
      put(1'b1, s);
      ack = !s;
   endtask : send

   task automatic write(input logic [6:0] addr, input logic [7:0] data,
                        output logic ack_a, output logic ack_d);
      drv = 1'b0;
      tick(10);
      scl = 1'b0;
      send({addr, 1'b0}, ack_a);
      send(data, ack_d);
      tick(3);
      drv = 1'b0;
      tick(7);
      scl = 1'b1;
      tick(10);
      drv = 1'b1;
      tick(10);
   endtask : write
endmodule : i2c_master_model

// *** tb/audio_clock_checker.sv ***
// Assertions on the top-level pins of the audio clock control block.
// Assumes it is bound into the top with the same settle parameter.
`timescale 1ns/1ps

module audio_clock_checker
#(
   parameter int SETTLE_CYCLES = 50
)
(
   input wire logic MCLK,
   input wire logic RSTN,
   input wire logic LINK_CLK,
   input wire logic MODE,
   input wire logic MODE_OPEN,
   input wire logic CLK_OR_FREQ_SEL_PIN,
   input wire logic DATA_OR_SCALE_SEL_OE,
   input wire logic ADDR_SEL_A_PIN,
   input wire logic ADDR_SEL_A_OPEN,
   input wire logic ADDR_SEL_B_PIN,
   input wire logic ADDR_SEL_B_OPEN,
   input wire logic AUDIO_CLK_A,
   input wire logic AUDIO_CLK_B,
   input wire logic REF_CLK_BUFFER_OUT,
   input wire logic [7:0] CTRL_BYTE,
   input wire logic SETTLING
);
   localparam int SETTLE_MAX = SETTLE_CYCLES + 8;
   logic sw;
   logic ref_off;
   logic [5:0] off_cnt;

   assign sw = !MODE || MODE_OPEN;
   assign ref_off = sw ? !CTRL_BYTE[7] : (!ADDR_SEL_A_PIN || ADDR_SEL_A_OPEN);

   // Reference gate sits in its own domain, so give it slack
   always_ff @(posedge MCLK or negedge RSTN)
   begin
      if (!RSTN)
         off_cnt <= 6'h00;
      else if (!ref_off)
         off_cnt <= 6'h00;
      else if (off_cnt != 6'h3f)
         off_cnt <= off_cnt + 6'h01;
   end

   sequence sw_a_off;
      (sw && !CTRL_BYTE[5]) [*6];
   endsequence
   sequence hw_b_off;
      (!sw && !ADDR_SEL_B_PIN && !ADDR_SEL_B_OPEN) [*6];
   endsequence

   a_audio_a_off: assert property (
      @(posedge MCLK) disable iff (!RSTN) sw_a_off |-> !AUDIO_CLK_A)
      else $error("audio A runs while disabled");
   a_hw_b_off: assert property (
      @(posedge MCLK) disable iff (!RSTN) hw_b_off |-> !AUDIO_CLK_B)
      else $error("audio B runs while strap disables it");
   a_mute_settle: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      SETTLING [*3] |-> !AUDIO_CLK_A && !AUDIO_CLK_B)
      else $error("audio clock runs while settling");
   a_settle_ends: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      // Moving straps may restart the mute in hardwired mode
      $rose(SETTLING) && sw |-> ##[1:SETTLE_MAX] !SETTLING)
      else $error("settling mute too long");
   a_reset_default: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      $rose(RSTN) |-> CTRL_BYTE == clkgen_pkg::CTRL_RESET && SETTLING)
      else $error("control byte not default after reset");
   a_ref_gated: assert property (
      @(posedge MCLK) disable iff (!RSTN)
      off_cnt >= 6'h28 |-> !REF_CLK_BUFFER_OUT)
      else $error("reference output runs while disabled");
   a_sda_quiet_hw: assert property (
      @(posedge LINK_CLK) disable iff (!RSTN)
      (!sw) [*6] |-> !DATA_OR_SCALE_SEL_OE)
      else $error("data line driven in hardwired mode");
   a_ack_scl_low: assert property (
      @(posedge LINK_CLK) disable iff (!RSTN)
      $rose(DATA_OR_SCALE_SEL_OE) |-> !CLK_OR_FREQ_SEL_PIN)
      else $error("acknowledge began while serial clock high");
   a_ack_held: assert property (
      @(posedge LINK_CLK) disable iff (!RSTN)
      DATA_OR_SCALE_SEL_OE && CLK_OR_FREQ_SEL_PIN |=> DATA_OR_SCALE_SEL_OE)
      else $error("acknowledge dropped while serial clock high");
endmodule : audio_clock_checker

bind audio_clock_config_control audio_clock_checker
   #(.SETTLE_CYCLES(SETTLE_CYCLES)) chk_u (.MCLK(MCLK), .RSTN(RSTN),
   .LINK_CLK(LINK_CLK), .MODE(MODE), .MODE_OPEN(MODE_OPEN),
   .CLK_OR_FREQ_SEL_PIN(CLK_OR_FREQ_SEL_PIN),
   .DATA_OR_SCALE_SEL_OE(DATA_OR_SCALE_SEL_OE),
   .ADDR_SEL_A_PIN(ADDR_SEL_A_PIN), .ADDR_SEL_A_OPEN(ADDR_SEL_A_OPEN),
   .ADDR_SEL_B_PIN(ADDR_SEL_B_PIN), .ADDR_SEL_B_OPEN(ADDR_SEL_B_OPEN),
   .AUDIO_CLK_A(AUDIO_CLK_A), .AUDIO_CLK_B(AUDIO_CLK_B),
   .REF_CLK_BUFFER_OUT(REF_CLK_BUFFER_OUT), .CTRL_BYTE(CTRL_BYTE),
   .SETTLING(SETTLING));

// *** tb/testbench.sv ***
// Self-checking bench: I2C writes, straps and output frequency counts.
// Assumes short settle counts; idle bus lines read high as straps.
`timescale 1ns/1ps

module testbench;
   logic mclk = 1'b0;
   logic link_clk = 1'b0;
   logic ref_clk = 1'b0;
   logic rstn, mode, mode_open, rate_open, aa, aa_o, ab, ab_o, rate, fo, so;
   logic scl, sda, oe, clk_a, clk_b, ref_out, settling;
   logic [7:0] ctrl;
   int miscompares = 0;
   int tests_run = 0;

   always #2.5 mclk = ~mclk;
   always #18.5 ref_clk = ~ref_clk;
   initial
   begin
      #13;
      forever #32 link_clk = ~link_clk;
   end

   audio_clock_config_control #(.SETTLE_CYCLES(50), .POWERON_CYCLES(100))
   dut_u (.MCLK(mclk), .RSTN(rstn), .LINK_CLK(link_clk), .REF_CLK(ref_clk),
      .MODE(mode), .MODE_OPEN(mode_open), .CLK_OR_FREQ_SEL_PIN(scl),
      .CLK_OR_FREQ_SEL_OPEN(fo), .DATA_OR_SCALE_SEL_IN(sda),
      .DATA_OR_SCALE_SEL_OPEN(so), .DATA_OR_SCALE_SEL_OUT(),
      .DATA_OR_SCALE_SEL_OE(oe), .RATE_SEL_PIN(rate),
      .RATE_SEL_OPEN(rate_open), .ADDR_SEL_A_PIN(aa), .ADDR_SEL_A_OPEN(aa_o),
      .ADDR_SEL_B_PIN(ab), .ADDR_SEL_B_OPEN(ab_o), .AUDIO_CLK_A(clk_a),
      .AUDIO_CLK_B(clk_b), .REF_CLK_BUFFER_OUT(ref_out), .CTRL_BYTE(ctrl),
      .SETTLING(settling));

   i2c_master_model partner_u (.link_clk(link_clk), .sda_oe(oe), .scl(scl),
      .sda(sda));

   task automatic end_of_test();
      $display("Checks run %0d, mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : end_of_test

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      tests_run++;
      if (got !== exp)
      begin
         miscompares++;
         $display("FAIL %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   task automatic step();
      @(posedge mclk);
      #1;
   endtask : step

   task automatic do_reset();
      rstn = 1'b0;
      repeat (2) @(posedge link_clk);
      step();
      rstn = 1'b1;
   endtask : do_reset

   task automatic settle();
      repeat (8) step();
      for (int i = 0; i < 2000 && settling !== 1'b0; i++)
         step();
      check("settling", 8'h00, {7'h00, settling});
   endtask : settle

   task automatic wr(input logic [6:0] addr, input logic [7:0] data,
                     input logic exp_ack);
      logic ack_a;
      logic ack_d;
      partner_u.write(addr, data, ack_a, ack_d);
      check("address ack", {7'h00, exp_ack}, {7'h00, ack_a});
      if (exp_ack)
         check("data ack", 8'h01, {7'h00, ack_d});
      step();
   endtask : wr

   // Edges in 2000 cycles (10 us); zero must be exact, else within 2
   task automatic measure(input logic [1:0] sel, input int f);
      int n;
      int e;
      logic prev;
      logic cur;
      n = 0;
      e = f / 100000;
      prev = 1'b0;
      repeat (2000)
      begin
         step();
         cur = sel == 2'h0 ? clk_a : (sel == 2'h1 ? clk_b : ref_out);
         if (cur === 1'b1 && prev === 1'b0)
            n++;
         prev = cur;
      end
      tests_run++;
      if (n > e + (e == 0 ? 0 : 2) || n < e - 2)
      begin
         miscompares++;
         $display("FAIL edges of output %0d expected %0d seen %0d", sel, e, n);
      end
      step();
   endtask : measure

   initial
   begin
      #500_000;
      miscompares++;
      end_of_test();
   end

   initial
   begin
      mode = 1'b0;
      mode_open = 1'b0;
      rate_open = 1'b0;
      rate = 1'b0;
      fo = 1'b0;
      so = 1'b0;
      aa = 1'b0;
      aa_o = 1'b1;
      ab = 1'b0;
      ab_o = 1'b1;
      do_reset();
      check("reset byte", 8'he0, ctrl);
      settle();
      measure(2'h0, 256 * 32000);
      measure(2'h1, 256 * 32000);
      wr(7'h61, 8'h00, 1'b0);
      check("byte kept", 8'he0, ctrl);
      rate_open = 1'b1;
      wr(7'h60, 8'h7a, 1'b1);
      check("byte", 8'h7a, ctrl);
      settle();
      measure(2'h0, 768 * 96000);
      measure(2'h2, 0);
      wr(7'h60, 8'h85, 1'b1);
      settle();
      measure(2'h0, 0);
      measure(2'h2, 27000000);
      wr(7'h60, 8'h67, 1'b1);
      settle();
      measure(2'h0, 384 * 12000);
      do_reset();
      check("byte after reset", 8'he0, ctrl);
      mode = 1'b1;
      rate_open = 1'b0;
      aa_o = 1'b0;
      ab_o = 1'b0;
      wr(7'h60, 8'h00, 1'b0);
      settle();
      measure(2'h0, 384 * 44100);
      measure(2'h1, 0);
      measure(2'h2, 0);
      rate = 1'b1;
      fo = 1'b1;
      so = 1'b1;
      settle();
      measure(2'h0, 768 * 96000);
      fo = 1'b0;
      so = 1'b0;
      rate_open = 1'b1;
      settle();
      measure(2'h0, 384 * 12000);
      aa = 1'b1;
      ab = 1'b1;
      settle();
      measure(2'h1, 384 * 12000);
      measure(2'h0, 0);
      measure(2'h2, 27000000);
      mode_open = 1'b1;
      settle();
      wr(7'h68, 8'h5a, 1'b1);
      check("byte open mode", 8'h5a, ctrl);
      settle();
      measure(2'h1, 768 * 96000);
      measure(2'h0, 0);
      end_of_test();
   end
endmodule : testbench
